/* File: dual_slope_adc_sequencer.sv */
// Purpose: Phase sequencer, result counter and multiplexed BCD scanner.
// Assumes: Inputs synchronous to i_sys_clk; comparator high = integrator
//   above zero.
// Notes: Results pass through a small FIFO to the digit scanner.
`timescale 1ns/1ps

module result_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire push_w = i_in_valid && o_in_ready;
  wire pop_w = o_out_valid && i_out_ready;
  wire ptr_eq_w = wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0];

  assign o_in_ready = !(ptr_eq_w && (wr_ptr_reg[AW] != rd_ptr_reg[AW]));
  assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
  assign o_out_data = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push_w) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end
endmodule // result_fifo

module dual_slope_adc_sequencer #(
  parameter int CONV_DIV = adc_seq_pkg::CONV_DIV,
  parameter logic [15:0] INT_COUNTS = adc_seq_pkg::INT_COUNTS,
  parameter logic [15:0] CYCLE_COUNTS = adc_seq_pkg::CYCLE_COUNTS,
  parameter logic [15:0] ZI_NORM_COUNTS = adc_seq_pkg::ZI_NORM_COUNTS,
  parameter logic [15:0] ZI_OVER_COUNTS = adc_seq_pkg::ZI_OVER_COUNTS,
  parameter logic [15:0] DIGIT_COUNTS = adc_seq_pkg::DIGIT_COUNTS
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_trigger,
  input wire logic i_comp_positive,
  output logic o_inputs_to_ground,
  output logic o_inputs_to_terminals,
  output logic o_neg_to_analog_ground_ref,
  output logic o_ref_cap_charge,
  output logic o_offset_loop_close,
  output logic o_ref_to_pos_input,
  output logic o_ref_reversed,
  output logic o_zero_loop_close,
  output logic o_busy,
  output logic o_polarity,
  output logic o_over_range,
  output logic o_under_range,
  output logic o_latch_n,
  output logic o_top_digit_select,
  output logic o_second_digit_select,
  output logic o_third_digit_select,
  output logic o_fourth_digit_select,
  output logic o_least_digit_select,
  output logic o_bcd_weight_one,
  output logic o_bcd_weight_two,
  output logic o_bcd_weight_four,
  output logic o_bcd_weight_eight
);
  localparam logic [15:0] DIV_LAST = 16'(CONV_DIV - 1);
  localparam logic [15:0] HALF_CYC = 16'(CONV_DIV / 2);
  localparam int FW = adc_seq_pkg::RESULT_W + 1;

  function automatic logic [19:0] bcd_inc(input logic [19:0] v);
    logic [19:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < adc_seq_pkg::DIGITS; i++) begin
      if (c) begin
        if (r[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  adc_seq_pkg::phase_t state_reg;
  adc_seq_pkg::phase_t state_next;
  logic [15:0] div_cnt_reg;
  logic [15:0] phase_cnt_reg;
  logic [15:0] cyc_cnt_reg;
  logic [15:0] zi_len_reg;
  logic [19:0] bcd_cnt_reg;
  logic [7:0] trig_cnt_reg;
  logic polarity_reg;
  logic over_pend_reg;
  logic hold_reg;
  logic armed_reg;
  logic start_req_reg;
  logic over_flag_reg;
  logic under_flag_reg;
  logic extend_reg;
  logic [2:0] dig_reg;
  logic [15:0] dcnt_reg;
  logic strobing_reg;
  logic [19:0] disp_reg;
  logic disp_over_reg;
  logic [4:0] digit_sel_reg;
  logic [3:0] bcd_reg;
  logic [15:0] low_cnt_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;

  // Conversion count enable and decoded phase.
  wire ce_w = div_cnt_reg == DIV_LAST;
  wire az_w = state_reg == adc_seq_pkg::ST_AZ;
  wire int_w = state_reg == adc_seq_pkg::ST_INT;
  wire deint_w = state_reg == adc_seq_pkg::ST_DEINT;
  wire zi_w = state_reg == adc_seq_pkg::ST_ZI;
  wire trig_filt_w = trig_cnt_reg >= adc_seq_pkg::TRIG_MIN_CYC;
  wire cross_w = i_comp_positive != polarity_reg;
  wire at_full_w = bcd_cnt_reg == adc_seq_pkg::BCD_LAST;
  wire [15:0] zi_last_w = zi_len_reg - 16'h1;
  wire int_end_w = phase_cnt_reg == INT_COUNTS - 16'h1;
  wire zi_end_w = phase_cnt_reg == zi_last_w;
  wire cyc_end_w = cyc_cnt_reg == CYCLE_COUNTS - 16'h1;
  wire go_w = az_w && (hold_reg ? start_req_reg : (cyc_end_w && trig_filt_w));
  wire hold_enter_w = az_w && !hold_reg && cyc_end_w && !trig_filt_w;
  wire push_req_w = ce_w && ((deint_w && cross_w) ||
                             (zi_w && over_pend_reg && zi_end_w));
  wire push_ok_w = push_req_w && fifo_in_ready;
  wire adv_w = ce_w && !(push_req_w && !fifo_in_ready);
  wire phase_chg_w = adv_w && (state_next != state_reg);
  wire under_w = (bcd_cnt_reg[19:16] == 4'h0) &&
                 (bcd_cnt_reg[15:0] <= adc_seq_pkg::UNDER_LIMIT_BCD);
  wire [FW-1:0] fifo_in_data_w = {over_pend_reg,
                                  over_pend_reg ? 20'h0 : bcd_cnt_reg};

  // Analog switch controls follow the phase register directly.
  assign o_inputs_to_ground = az_w;
  assign o_ref_cap_charge = az_w;
  assign o_offset_loop_close = az_w;
  assign o_inputs_to_terminals = int_w;
  assign o_neg_to_analog_ground_ref = az_w || deint_w || zi_w;
  assign o_ref_to_pos_input = deint_w;
  assign o_ref_reversed = deint_w && !polarity_reg;
  assign o_zero_loop_close = zi_w;
  assign o_busy = int_w || deint_w || (zi_w && over_pend_reg);
  assign o_polarity = polarity_reg;
  assign o_over_range = over_flag_reg;
  assign o_under_range = under_flag_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      adc_seq_pkg::ST_AZ: if (go_w) state_next = adc_seq_pkg::ST_INT;
      adc_seq_pkg::ST_INT: if (int_end_w) state_next = adc_seq_pkg::ST_DEINT;
      adc_seq_pkg::ST_DEINT: if (cross_w || at_full_w) begin
        state_next = adc_seq_pkg::ST_ZI;
      end
      adc_seq_pkg::ST_ZI: if (zi_end_w) state_next = adc_seq_pkg::ST_AZ;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || ce_w) begin
      div_cnt_reg <= 16'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h1;
    end
  end

  // Trigger is qualified by its high time so short glitches cannot start.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_trigger) begin
      trig_cnt_reg <= 8'h0;
    end else if (!trig_filt_w) begin
      trig_cnt_reg <= trig_cnt_reg + 8'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg <= adc_seq_pkg::ST_AZ;
      phase_cnt_reg <= 16'h0;
      cyc_cnt_reg <= 16'h0;
      zi_len_reg <= ZI_NORM_COUNTS;
      bcd_cnt_reg <= 20'h0;
      polarity_reg <= 1'b0;
      over_pend_reg <= 1'b0;
      hold_reg <= 1'b1;
    end else if (adv_w) begin
      state_reg <= state_next;
      phase_cnt_reg <= phase_chg_w ? 16'h0 : phase_cnt_reg + 16'h1;
      if (go_w) begin
        cyc_cnt_reg <= 16'h0;
      end else if (!hold_reg && !hold_enter_w) begin
        cyc_cnt_reg <= cyc_cnt_reg + 16'h1;
      end
      if (hold_enter_w) begin
        hold_reg <= 1'b1;
      end else if (go_w) begin
        hold_reg <= 1'b0;
      end
      if (int_w && int_end_w) begin
        polarity_reg <= i_comp_positive;
        bcd_cnt_reg <= 20'h0;
      end
      if (deint_w && !cross_w && !at_full_w) begin
        bcd_cnt_reg <= bcd_inc(bcd_cnt_reg);
      end
      if (deint_w && cross_w) begin
        zi_len_reg <= ZI_NORM_COUNTS;
      end else if (deint_w && at_full_w) begin
        zi_len_reg <= ZI_OVER_COUNTS;
        over_pend_reg <= 1'b1;
      end
      if (zi_w && zi_end_w) begin
        over_pend_reg <= 1'b0;
      end
    end
  end

  // A start request is only armed once a cycle has finished and the
  // trigger has been seen low, so pulses inside a cycle are dropped.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      armed_reg <= 1'b1;
      start_req_reg <= 1'b0;
    end else begin
      armed_reg <= hold_reg && (armed_reg || !trig_filt_w);
      if (adv_w && go_w) begin
        start_req_reg <= 1'b0;
      end else if (hold_reg && armed_reg && trig_filt_w) begin
        start_req_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      over_flag_reg <= 1'b0;
      under_flag_reg <= 1'b0;
    end else begin
      if (phase_chg_w && state_next == adc_seq_pkg::ST_DEINT) begin
        over_flag_reg <= 1'b0;
      end
      if (phase_chg_w && state_next == adc_seq_pkg::ST_INT) begin
        under_flag_reg <= 1'b0;
      end
      if (push_ok_w) begin
        over_flag_reg <= over_pend_reg;
        under_flag_reg <= !over_pend_reg && under_w;
      end
    end
  end

  // Digit scanner runs free; a new result is taken only at a top digit.
  wire ext_w = (dig_reg == adc_seq_pkg::TOP_DIGIT) && extend_reg;
  wire [15:0] period_last_w = DIGIT_COUNTS + {15'h0, ext_w} - 16'h1;
  wire dig_end_w = ce_w && (dcnt_reg == period_last_w);
  wire top_start_w = dig_end_w && (dig_reg == 3'h0);
  wire pop_w = top_start_w && fifo_out_valid;
  wire extend_set_w = phase_chg_w &&
    (state_next == adc_seq_pkg::ST_AZ || state_next == adc_seq_pkg::ST_DEINT);
  wire blank_w = over_flag_reg && !strobing_reg;
  wire latch_low_w = strobing_reg && (dcnt_reg == adc_seq_pkg::STROBE_AT) &&
                     (div_cnt_reg < HALF_CYC);
  wire [4:0] sel_next_w = blank_w ? 5'h00 : 5'(5'h01 << dig_reg);
  wire [3:0] bcd_next_w = disp_reg[{dig_reg, 2'b00} +: 4];

  result_fifo #(
    .WIDTH(FW),
    .DEPTH(adc_seq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_in_valid(push_req_w),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data_w),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop_w),
    .o_out_data(fifo_out_data)
  );

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      dig_reg <= adc_seq_pkg::TOP_DIGIT;
      dcnt_reg <= 16'h0;
      strobing_reg <= 1'b0;
      disp_reg <= 20'h0;
      disp_over_reg <= 1'b0;
      extend_reg <= 1'b0;
    end else begin
      if (ce_w) begin
        dcnt_reg <= dig_end_w ? 16'h0 : dcnt_reg + 16'h1;
      end
      if (dig_end_w) begin
        dig_reg <= (dig_reg == 3'h0) ? adc_seq_pkg::TOP_DIGIT
                                     : dig_reg - 3'h1;
      end
      if (top_start_w) begin
        strobing_reg <= fifo_out_valid;
      end
      if (pop_w) begin
        {disp_over_reg, disp_reg} <= fifo_out_data;
      end
      if (dig_end_w && dig_reg == adc_seq_pkg::TOP_DIGIT) begin
        extend_reg <= 1'b0;
      end
      if (extend_set_w) begin
        extend_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      digit_sel_reg <= 5'h00;
      bcd_reg <= 4'h0;
      o_latch_n <= 1'b1;
      low_cnt_reg <= 16'h0;
    end else begin
      digit_sel_reg <= sel_next_w;
      bcd_reg <= bcd_next_w;
      o_latch_n <= !latch_low_w;
      low_cnt_reg <= o_latch_n ? 16'h0 : low_cnt_reg + 16'h1;
    end
  end

  assign o_top_digit_select = digit_sel_reg[4];
  assign o_second_digit_select = digit_sel_reg[3];
  assign o_third_digit_select = digit_sel_reg[2];
  assign o_fourth_digit_select = digit_sel_reg[1];
  assign o_least_digit_select = digit_sel_reg[0];
  assign o_bcd_weight_one = bcd_reg[0];
  assign o_bcd_weight_two = bcd_reg[1];
  assign o_bcd_weight_four = bcd_reg[2];
  assign o_bcd_weight_eight = bcd_reg[3];

  phase_order_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    state_reg != $past(state_reg) |->
      (int_w && $past(az_w)) || (deint_w && $past(int_w)) ||
      (zi_w && $past(deint_w)) || (az_w && $past(zi_w)))
    else $error("phase order broken");
  int_length_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(deint_w) |-> $past(phase_cnt_reg) == INT_COUNTS - 16'h1)
    else $error("integrate length wrong");
  neg_ground_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_neg_to_analog_ground_ref != o_inputs_to_terminals)
    else $error("negative input grounding wrong");
  polarity_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    deint_w && $past(deint_w) |-> $stable(o_polarity))
    else $error("polarity changed in deintegrate");
  zi_length_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $fell(zi_w) |-> $past(phase_cnt_reg) == $past(zi_last_w))
    else $error("zero integrator length wrong");
  cycle_len_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(int_w) && !$past(hold_reg) |->
      $past(cyc_cnt_reg) == CYCLE_COUNTS - 16'h1)
    else $error("cycle length wrong");
  busy_rise_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(o_busy) |-> int_w && !o_under_range)
    else $error("busy rose outside integrate");
  over_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    deint_w |-> ##1 (!o_over_range || !deint_w))
    else $error("over-range not cleared");
  blank_digits_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    blank_w |=> digit_sel_reg == 5'h00)
    else $error("digits not blanked");
  latch_width_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(o_latch_n) |-> low_cnt_reg == HALF_CYC)
    else $error("latch low width wrong");
endmodule // dual_slope_adc_sequencer

/* File: adc_seq_pkg.sv */
// Purpose: Shared constants and types for the dual-slope converter sequencer.
// Assumes: One 200 MHz system clock; conversion counts are clock enables.
// Notes: Counts are in conversion-clock counts unless named _CYC.
// Contract
// - Phases run auto-zero, integrate, deintegrate, zero-integrator.
// - Auto-zero grounds inputs, charges reference, closes offset loop.
// - Integrate connects terminals fixed time, records polarity.
// - Deintegrate applies reference oriented by recorded polarity.
// - Result is deintegrate count to zero crossing.
// - Twice reference is full scale; beyond flags over-range.
// - Zero-integrator lasts 100-200 counts, 6200 after over-range.
// - Negative input grounded only in three non-integrate phases.
// - Trigger high starts cycles every 40002 counts.
// - Trigger low finishes current cycle then holds reading.
// - In hold, trigger pulse over 300 ns starts cycle.
// - Trigger pulses during an unfinished cycle are ignored.
// - First latch pulse 101 counts after cycle end.
// - Top digit value shown, latch high 201 counts.
// - Latch low half count at digit-select midpoint.
// - Latch step repeats per digit, top down to least.
// - After least digit, scanning continues without latch pulses.
// - No continued scanning after an over-range conversion.
// - First top-digit period in auto-zero, deintegrate one longer.
// - Busy fall to first latch varies with input.
// - Busy rises at integrate, falls after crossing or over-range.
// - Each digit select high 200 counts with its value.
// - Over-range flag set at busy end, cleared at deintegrate.
// - Under-range flag when result at most 1800, cleared at integrate.
package adc_seq_pkg;

  typedef enum logic [1:0] {ST_AZ, ST_INT, ST_DEINT, ST_ZI} phase_t;

  // System clock period 5 ns, conversion clock 120 kHz.
  localparam int SYS_CLK_HZ = 32'h0bebc200;
  localparam int SYS_PERIOD_NS = 32'h5;
  localparam int CONV_CLK_HZ = 32'h0001d4c0;
  localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;

  // Shortest accepted trigger pulse: 300 ns.
  localparam int TRIG_MIN_NS = 32'h12c;
  localparam logic [7:0] TRIG_MIN_CYC =
    8'((TRIG_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  localparam logic [15:0] INT_COUNTS = 16'h2710;     // 10000
  localparam logic [15:0] CYCLE_COUNTS = 16'h9c42;   // 40002
  localparam logic [15:0] ZI_NORM_COUNTS = 16'h00c8; // 200
  localparam logic [15:0] ZI_OVER_COUNTS = 16'h1838; // 6200
  localparam logic [15:0] DIGIT_COUNTS = 16'h00c8;   // 200
  localparam logic [15:0] STROBE_AT = 16'h0064;      // 101st count

  localparam int DIGITS = 5;
  localparam int RESULT_W = 4 * DIGITS;
  localparam logic [2:0] TOP_DIGIT = 3'h4;
  localparam logic [19:0] BCD_LAST = 20'h19999;
  localparam logic [15:0] UNDER_LIMIT_BCD = 16'h1800;
  localparam int FIFO_DEPTH = 8;

endpackage

/* File: adc_front_model.sv */
// Purpose: Far-side model: integrator comparator plus a latch-driven host.
// Assumes: The crossing comes after i_target counts of deintegrate.
// Notes: A digit is captured on the first clock the latch line is low.
`timescale 1ns/1ps
module adc_front_model #(
  parameter int CONV_DIV = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_inputs_to_terminals,
  input wire logic i_ref_to_pos_input,
  input wire logic i_positive,
  input wire logic [15:0] i_target,
  input wire logic i_latch_n,
  input wire logic [4:0] i_selects,
  input wire logic [3:0] i_bcd,
  output logic o_comp_positive
);
  logic comp_reg = 1'b0;
  logic latch_d = 1'b1;
  logic crossed;
  logic [4:0] sel_d = 5'h00;
  int deint_clk = 0;
  int low_clk = 0;
  int sel_clk = 0;
  int now_clk = 0;
  logic [4:0] cap_sel[$];
  logic [3:0] cap_bcd[$];
  int cap_off[$];
  int cap_width[$];
  int cap_time[$];

  assign o_comp_positive = comp_reg;
  assign crossed = deint_clk >= int'(i_target) * CONV_DIV;

  // Outside the integrating phases the comparator means nothing, so it
  // toggles every clock rather than resting at a convenient level.
  always @(posedge i_sys_clk) begin
    deint_clk <= i_ref_to_pos_input ? deint_clk + 1 : 0;
    if (i_inputs_to_terminals) begin
      comp_reg <= i_positive;
    end else if (i_ref_to_pos_input) begin
      comp_reg <= crossed ? ~i_positive : i_positive;
    end else begin
      comp_reg <= ~comp_reg;
    end
  end

  always @(posedge i_sys_clk) begin
    now_clk <= now_clk + 1;
    latch_d <= i_latch_n;
    sel_d <= i_selects;
    sel_clk <= (i_selects != sel_d) ? 1 : sel_clk + 1;
    low_clk <= i_latch_n ? 0 : low_clk + 1;
    if (latch_d && !i_latch_n) begin
      cap_sel.push_back(i_selects);
      cap_bcd.push_back(i_bcd);
      cap_off.push_back(sel_clk);
      cap_time.push_back(now_clk);
    end
    if (!latch_d && i_latch_n) begin
      cap_width.push_back(low_clk);
    end
  end
endmodule // adc_front_model

/* File: dual_slope_adc_sequencer_tb.sv */
// Purpose: Self-checking bench for the dual-slope converter sequencer.
// Assumes: Shortened counts; every conversion stays below full scale.
// Notes: Over-range needs 20000 deintegrate counts, too long to run here.
`timescale 1ns/1ps
module dual_slope_adc_sequencer_tb;
  localparam int DIV = 2;
  localparam int INT_N = 20;
  localparam int CYC_N = 2500;
  localparam int ZI_N = 200;
  localparam int DIG_N = 200;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_trigger = 1'b0;
  logic positive = 1'b1;
  logic [15:0] tgt = 16'h0000;
  logic comp;
  logic o_inputs_to_ground, o_inputs_to_terminals, o_ref_cap_charge;
  logic o_neg_to_analog_ground_ref, o_offset_loop_close, o_ref_reversed;
  logic o_ref_to_pos_input, o_zero_loop_close, o_busy, o_polarity;
  logic o_over_range, o_under_range, o_latch_n;
  logic o_top_digit_select, o_second_digit_select, o_third_digit_select;
  logic o_fourth_digit_select, o_least_digit_select;
  logic o_bcd_weight_one, o_bcd_weight_two;
  logic o_bcd_weight_four, o_bcd_weight_eight;
  logic [4:0] sel;
  logic [3:0] bcd;
  int miscompares = 0;
  int samples_checked = 0;

  assign sel = {o_top_digit_select, o_second_digit_select,
    o_third_digit_select, o_fourth_digit_select, o_least_digit_select};
  assign bcd = {o_bcd_weight_eight, o_bcd_weight_four, o_bcd_weight_two,
    o_bcd_weight_one};

  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  dual_slope_adc_sequencer #(
    .CONV_DIV(DIV),
    .INT_COUNTS(16'(INT_N)),
    .CYCLE_COUNTS(16'(CYC_N)),
    .ZI_NORM_COUNTS(16'(ZI_N)),
    .ZI_OVER_COUNTS(16'h001e),
    .DIGIT_COUNTS(16'(DIG_N))
  ) i_dut (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_trigger(i_trigger),
    .i_comp_positive(comp),
    .o_inputs_to_ground(o_inputs_to_ground),
    .o_inputs_to_terminals(o_inputs_to_terminals),
    .o_neg_to_analog_ground_ref(o_neg_to_analog_ground_ref),
    .o_ref_cap_charge(o_ref_cap_charge),
    .o_offset_loop_close(o_offset_loop_close),
    .o_ref_to_pos_input(o_ref_to_pos_input),
    .o_ref_reversed(o_ref_reversed),
    .o_zero_loop_close(o_zero_loop_close),
    .o_busy(o_busy),
    .o_polarity(o_polarity),
    .o_over_range(o_over_range),
    .o_under_range(o_under_range),
    .o_latch_n(o_latch_n),
    .o_top_digit_select(o_top_digit_select),
    .o_second_digit_select(o_second_digit_select),
    .o_third_digit_select(o_third_digit_select),
    .o_fourth_digit_select(o_fourth_digit_select),
    .o_least_digit_select(o_least_digit_select),
    .o_bcd_weight_one(o_bcd_weight_one),
    .o_bcd_weight_two(o_bcd_weight_two),
    .o_bcd_weight_four(o_bcd_weight_four),
    .o_bcd_weight_eight(o_bcd_weight_eight)
  );

  adc_front_model #(.CONV_DIV(DIV)) i_front (
    .i_sys_clk(i_sys_clk),
    .i_inputs_to_terminals(o_inputs_to_terminals),
    .i_ref_to_pos_input(o_ref_to_pos_input),
    .i_positive(positive),
    .i_target(tgt),
    .i_latch_n(o_latch_n),
    .i_selects(sel),
    .i_bcd(bcd),
    .o_comp_positive(comp)
  );

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, want, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [3:0] digit_of(input int n, input int i);
    return 4'((n / (10 ** (4 - i))) % 10);
  endfunction

  task automatic pulse(input int len);
    @(posedge i_sys_clk);
    i_trigger <= 1'b1;
    repeat (len) @(posedge i_sys_clk);
    i_trigger <= 1'b0;
  endtask

  task automatic wait_busy(input logic val);
    int t;
    t = 0;
    while (o_busy !== val && t < 2 * CYC_N * DIV) begin
      @(negedge i_sys_clk);
      t++;
    end
    check("busy level", o_busy, val);
  endtask

  task automatic wait_latches(input int base);
    int t;
    t = 0;
    while (i_front.cap_sel.size() < base + 5 && t < 12000) begin
      @(negedge i_sys_clk);
      t++;
    end
    repeat (4) @(negedge i_sys_clk);
    check("latch count", i_front.cap_sel.size(), base + 5);
  endtask

  task automatic run_one(input int target, input logic pos);
    int bclk;
    int zi;
    int n;
    int base;
    int rise;
    tgt <= 16'(target);
    positive <= pos;
    base = i_front.cap_sel.size();
    fork
      pulse($urandom_range(62, 100));
    join_none
    wait_busy(1'b1);
    rise = i_front.now_clk;
    bclk = 0;
    while (o_busy === 1'b1 && bclk < 20000) begin
      if (bclk == INT_N * DIV / 2) begin
        check("to terminals", o_inputs_to_terminals, 1'b1);
        check("neg ground", o_neg_to_analog_ground_ref, 1'b0);
        check("under range clear", o_under_range, 1'b0);
      end
      if (bclk == INT_N * DIV + 1) begin
        check("ref applied", o_ref_to_pos_input, 1'b1);
        check("ref orientation", o_ref_reversed, !pos);
        check("polarity", o_polarity, pos);
        check("neg ground deint", o_neg_to_analog_ground_ref, 1'b1);
      end
      @(negedge i_sys_clk);
      bclk++;
    end
    n = bclk / DIV - INT_N - 1;
    check("busy whole counts", bclk % DIV, 0);
    check("result", n >= target - 1 && n <= target + 1, 1'b1);
    zi = 0;
    while (o_zero_loop_close === 1'b1 && zi < 20000) begin
      @(negedge i_sys_clk);
      zi++;
    end
    check("zero integrate", zi, ZI_N * DIV);
    check("under range", o_under_range, n <= 1800);
    check("over range", o_over_range, 1'b0);
    check("auto zero", {o_inputs_to_ground, o_ref_cap_charge,
      o_offset_loop_close, o_neg_to_analog_ground_ref,
      o_inputs_to_terminals}, 5'h1e);
    pulse(80);
    wait_latches(base);
    for (int i = 0; i < 5; i++) begin
      check("latch select", i_front.cap_sel[base + i], 5'h10 >> i);
      check("latch digit", i_front.cap_bcd[base + i], digit_of(n, i));
      check("latch width", i_front.cap_width[base + i], DIV / 2);
      if (i > 0) check("midpoint", i_front.cap_off[base + i], 100 * DIV);
      if (i > 1) check("digit period", i_front.cap_time[base + i] -
        i_front.cap_time[base + i - 1], DIG_N * DIV);
    end
    while (i_front.now_clk - rise < CYC_N * DIV + 20) @(negedge i_sys_clk);
    check("no restart", o_busy, 1'b0);
  endtask

  task automatic run_mode();
    int t1;
    int base;
    logic [4:0] seen;
    tgt <= 16'h0100;
    positive <= 1'b1;
    @(posedge i_sys_clk);
    i_trigger <= 1'b1;
    wait_busy(1'b1);
    t1 = i_front.now_clk;
    wait_busy(1'b0);
    wait_busy(1'b1);
    check("run period", i_front.now_clk - t1, CYC_N * DIV);
    t1 = i_front.now_clk;
    @(posedge i_sys_clk);
    i_trigger <= 1'b0;
    wait_busy(1'b0);
    base = i_front.cap_sel.size();
    wait_latches(base);
    base = i_front.cap_sel.size();
    seen = 5'h00;
    repeat (6 * DIG_N * DIV) begin
      @(negedge i_sys_clk);
      seen = seen | sel;
    end
    check("scan continues", seen, 5'h1f);
    check("no more latches", i_front.cap_sel.size(), base);
    while (i_front.now_clk - t1 < CYC_N * DIV + 20) @(negedge i_sys_clk);
    check("reading held", o_busy, 1'b0);
  endtask

  initial begin
    repeat (90000) @(posedge i_sys_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    void'($urandom(73352));
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(negedge i_sys_clk);
    check("idle busy", o_busy, 1'b0);
    check("idle latch", o_latch_n, 1'b1);
    check("idle auto zero", o_inputs_to_ground, 1'b1);
    run_one(0, 1'b1);
    run_one(1800, 1'b0);
    run_one(1801, 1'b1);
    repeat (3) run_one($urandom_range(2, 2200), 1'($urandom_range(0, 1)));
    run_mode();
    give_verdict();
  end
endmodule // dual_slope_adc_sequencer_tb
